/* design/mcuid_map.svh */
// named offsets, field positions, opcode values and reset values of the
// instruction decoder; assumes it is included by its bare name.
//
// Contract
// RULE1 - decode 75 standard instructions plus eight extended-set ones.
// RULE2 - words are 16 bits; four instructions span two program words.
// RULE3 - a word splits into an opcode and one or more operand fields.
// RULE4 - classify as byte, bit, literal or control operation.
// RULE5 - byte operations carry file address, destination and bank select.
// RULE6 - destination zero writes working register, one writes the file.
// RULE7 - bit operations carry file address, bit number and bank select.
// RULE8 - literals carry a value and pointer select, or no operand.
// RULE9 - control carries program address, fast mode, table mode or none.
// RULE10 - second word of a double has upper four bits all ones.
// RULE11 - a second word executed alone acts as a no-operation.
// RULE12 - single word takes one cycle, two on true test or jump.
// RULE13 - a double-word instruction takes two instruction cycles.
// RULE14 - an instruction cycle is four oscillator periods.
// RULE15 - increment-skip adds one, writes per destination, keeps flags.
// RULE16 - zero result discards next word; three cycles if it is double.
// RULE17 - access select zero uses access bank, else bank register.
// RULE18 - access zero, extended set on, address up to 95: indexed mode.
// RULE19 - quarters: decode, read source, process, write destination.
// RULE20 - the file address field is eight bits, 0 through 255.
`ifndef MCUID_MAP_SVH
`define MCUID_MAP_SVH

// ****************************************************************
// field positions
// ****************************************************************
`define MCUID_NIB_HI    15
`define MCUID_NIB_LO    12
`define MCUID_OPX_HI    15
`define MCUID_OPX_LO    10
`define MCUID_BYTE_HI   15
`define MCUID_BYTE_LO   8
`define MCUID_F_HI      7
`define MCUID_F_LO      0
`define MCUID_D_BIT     9
`define MCUID_A_BIT     8
`define MCUID_B_HI      11
`define MCUID_B_LO      9
`define MCUID_K_HI      7
`define MCUID_K_LO      0
`define MCUID_P_HI      5
`define MCUID_P_LO      4
`define MCUID_N_HI      10
`define MCUID_N_LO      0
`define MCUID_S_BIT     0
`define MCUID_M_HI      1
`define MCUID_M_LO      0
`define MCUID_EXT_HI    9
`define MCUID_EXT_MID   8
`define MCUID_EXT_LO    7
`define MCUID_CALL_HI   15
`define MCUID_CALL_LO   9
`define MCUID_EXTS_HI   15
`define MCUID_EXTS_LO   10

// ****************************************************************
// opcode values
// ****************************************************************
`define MCUID_SECOND_NIB  4'hF
`define MCUID_MOVE_NIB    4'hC
`define MCUID_BRANCH_NIB  4'hD
`define MCUID_LIT_NIB     4'hE
`define MCUID_CTRL_NIB    4'h0
`define MCUID_BYTE_NIB_LO 4'h1
`define MCUID_BYTE_NIB_HI 4'h6
`define MCUID_BIT_NIB_LO  4'h7
`define MCUID_BIT_NIB_HI  4'hB
`define MCUID_INCSKIP_OPX 6'h0F
`define MCUID_CALL_OP7    7'h76
`define MCUID_PTRLD_BYTE  8'hEE
`define MCUID_GOTO_BYTE   8'hEF
`define MCUID_EXT_OP6     6'h3A

// ****************************************************************
// limits and reset values
// ****************************************************************
`define MCUID_IDX_MAX     8'h5F
`define MCUID_PC_RST      16'h0000
`define MCUID_PC_STEP     16'h0001
`define MCUID_BYTE_ZERO   8'h00
`define MCUID_BYTE_ONE    8'h01
`define MCUID_WORD_ZERO   16'h0000

`endif

/* design/mcuid_pkg.sv */
// types shared by the instruction decoder files.
// assumes mcuid_map.svh is on the include path.
`include "mcuid_map.svh"

package mcuid_pkg;

  typedef enum logic [3:0] {
    MCUID_Q1 = 4'h1,
    MCUID_Q2 = 4'h2,
    MCUID_Q3 = 4'h4,
    MCUID_Q4 = 4'h8
  } mcuid_phase_t;

  typedef enum logic [4:0] {
    MCUID_CL_BYTE = 5'h01,
    MCUID_CL_BIT  = 5'h02,
    MCUID_CL_LIT  = 5'h04,
    MCUID_CL_CTRL = 5'h08,
    MCUID_CL_NOP  = 5'h10
  } mcuid_class_t;

  typedef enum logic [2:0] {
    MCUID_MD_ACCESS  = 3'h1,
    MCUID_MD_BANKED  = 3'h2,
    MCUID_MD_INDEXED = 3'h4
  } mcuid_mode_t;

  typedef enum logic [2:0] {
    MCUID_SL_EXEC    = 3'h1,
    MCUID_SL_OPERAND = 3'h2,
    MCUID_SL_FLUSH   = 3'h4
  } mcuid_slot_t;

  // first word of one of the four two-word instructions
  function automatic logic mcuid_is_double(input logic [15:0] w);
    logic [3:0] nib;
    nib = w[`MCUID_NIB_HI:`MCUID_NIB_LO];
    return (nib == `MCUID_MOVE_NIB) ||
           (w[`MCUID_CALL_HI:`MCUID_CALL_LO] == `MCUID_CALL_OP7) ||
           (w[`MCUID_BYTE_HI:`MCUID_BYTE_LO] == `MCUID_PTRLD_BYTE) ||
           (w[`MCUID_BYTE_HI:`MCUID_BYTE_LO] == `MCUID_GOTO_BYTE);
  endfunction : mcuid_is_double

endpackage : mcuid_pkg

/* design/mcuid_phase.sv */
// quarter-cycle sequencer: four clock periods make one instruction cycle.
// assumes one free-running clock and a synchronous active-low reset.
`timescale 1ns/1ps

module mcuid_phase (
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rstn_in,
  // quarter in progress
  output mcuid_pkg::mcuid_phase_t   phase_out
);

  mcuid_pkg::mcuid_phase_t phase_q;
  mcuid_pkg::mcuid_phase_t phase_d;

  always_comb begin
    case (phase_q)
      mcuid_pkg::MCUID_Q1: phase_d = mcuid_pkg::MCUID_Q2;
      mcuid_pkg::MCUID_Q2: phase_d = mcuid_pkg::MCUID_Q3;
      mcuid_pkg::MCUID_Q3: phase_d = mcuid_pkg::MCUID_Q4;
      mcuid_pkg::MCUID_Q4: phase_d = mcuid_pkg::MCUID_Q1;
      default:             phase_d = mcuid_pkg::MCUID_Q1;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      phase_q <= mcuid_pkg::MCUID_Q1;
    end else begin
      phase_q <= phase_d; // see RULE14
    end
  end

  assign phase_out = phase_q;

endmodule : mcuid_phase

/* design/mcuid_fields.sv */
// combinational split of one program word into class and operand fields.
// assumes the word is stable for the whole decode quarter.
`timescale 1ns/1ps
`include "mcuid_map.svh"

module mcuid_fields (
  // program word
  input  wire logic [15:0]          word_in,
  // class
  output mcuid_pkg::mcuid_class_t   class_out,
  output logic                      incskip_out,
  output logic                      branch_out,
  output logic                      ext_op_out,
  output logic [2:0]                ext_idx_out,
  // operand fields
  output logic [7:0]                file_out,
  output logic                      dest_out,
  output logic                      access_out,
  output logic [2:0]                bit_num_out,
  output logic [7:0]                literal_out,
  output logic [1:0]                ptr_sel_out,
  output logic [10:0]               pm_field_out,
  output logic                      fast_out,
  output logic [1:0]                table_mode_out
);

  logic [3:0] nib;
  logic       is_byte;
  logic       is_bit;
  logic       is_lit;
  logic       is_call;
  logic       is_goto;

  assign nib     = word_in[`MCUID_NIB_HI:`MCUID_NIB_LO];
  // see RULE4
  assign is_byte = ((nib >= `MCUID_BYTE_NIB_LO) &&
                    (nib <= `MCUID_BYTE_NIB_HI)) ||
                   (nib == `MCUID_MOVE_NIB);
  assign is_bit  = (nib >= `MCUID_BIT_NIB_LO) && (nib <= `MCUID_BIT_NIB_HI);
  assign is_call = word_in[`MCUID_CALL_HI:`MCUID_CALL_LO] == `MCUID_CALL_OP7;
  assign is_goto = word_in[`MCUID_BYTE_HI:`MCUID_BYTE_LO] == `MCUID_GOTO_BYTE;
  assign is_lit  = (nib == `MCUID_LIT_NIB) && !is_call && !is_goto;

  always_comb begin
    if (nib == `MCUID_SECOND_NIB) begin
      class_out = mcuid_pkg::MCUID_CL_NOP; // see RULE11
    end else if (is_byte) begin
      class_out = mcuid_pkg::MCUID_CL_BYTE;
    end else if (is_bit) begin
      class_out = mcuid_pkg::MCUID_CL_BIT;
    end else if (is_lit) begin
      class_out = mcuid_pkg::MCUID_CL_LIT;
    end else begin
      class_out = mcuid_pkg::MCUID_CL_CTRL;
    end
  end

  // see RULE3
  assign incskip_out = word_in[`MCUID_OPX_HI:`MCUID_OPX_LO] ==
                       `MCUID_INCSKIP_OPX; // see RULE15
  assign branch_out  = nib == `MCUID_BRANCH_NIB;
  // eight extended codes share one prefix; see RULE1
  assign ext_op_out  = word_in[`MCUID_EXTS_HI:`MCUID_EXTS_LO] ==
                       `MCUID_EXT_OP6;
  assign ext_idx_out = {word_in[`MCUID_EXT_HI], word_in[`MCUID_EXT_MID],
                        word_in[`MCUID_EXT_LO]};
  // see RULE5, RULE7, RULE20
  assign file_out       = word_in[`MCUID_F_HI:`MCUID_F_LO];
  assign dest_out       = word_in[`MCUID_D_BIT];
  assign access_out     = word_in[`MCUID_A_BIT];
  assign bit_num_out    = word_in[`MCUID_B_HI:`MCUID_B_LO];
  // see RULE8
  assign literal_out    = word_in[`MCUID_K_HI:`MCUID_K_LO];
  assign ptr_sel_out    = word_in[`MCUID_P_HI:`MCUID_P_LO];
  // see RULE9
  assign pm_field_out   = word_in[`MCUID_N_HI:`MCUID_N_LO];
  assign fast_out       = word_in[`MCUID_S_BIT];
  assign table_mode_out = word_in[`MCUID_M_HI:`MCUID_M_LO];

endmodule : mcuid_fields

/* design/mcuid_core.sv */
// instruction decode and execution timing of the 8-bit core.
// assumes program memory and data file run on clk_in and answer in time:
// the program word at prog_addr_out is valid at the end of each fourth
// quarter, and file read data is valid at the end of the second quarter.
`timescale 1ns/1ps
`include "mcuid_map.svh"

module mcuid_core (
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rstn_in,
  // configuration
  input  wire logic                 ext_set_en_in,
  input  wire logic [7:0]           bank_select_register_in,
  // program memory
  output logic [15:0]               prog_addr_out,
  input  wire logic [15:0]          prog_data_in,
  // data file
  output logic [7:0]                file_addr_out,
  output logic [7:0]                bank_out,
  output mcuid_pkg::mcuid_mode_t    file_mode_out,
  output logic                      file_rd_out,
  input  wire logic [7:0]           file_rd_data_in,
  output logic                      file_wr_out,
  output logic [7:0]                file_wr_data_out,
  output logic [7:0]                working_register_out,
  // decoded instruction
  output mcuid_pkg::mcuid_phase_t   phase_out,
  output mcuid_pkg::mcuid_class_t   class_out,
  output logic [15:0]               op_word_out,
  output logic [15:0]               operand_word_out,
  output logic                      double_out,
  output logic                      nop_cycle_out,
  output logic                      dest_out,
  output logic                      access_out,
  output logic [2:0]                bit_num_out,
  output logic [7:0]                literal_out,
  output logic [1:0]                ptr_sel_out,
  output logic [10:0]               pm_field_out,
  output logic                      fast_out,
  output logic [1:0]                table_mode_out,
  output logic                      ext_op_out,
  output logic [2:0]                ext_idx_out
);

  // ****************************************************************
  // quarter sequencer and field split
  // ****************************************************************
  mcuid_pkg::mcuid_phase_t phase;
  mcuid_pkg::mcuid_class_t dec_class;
  logic        dec_incskip;
  logic        dec_branch;
  logic        dec_ext;
  logic [2:0]  dec_ext_idx;
  logic [7:0]  dec_file;
  logic        dec_dest;
  logic        dec_access;
  logic [2:0]  dec_bit;
  logic [7:0]  dec_lit;
  logic [1:0]  dec_psel;
  logic [10:0] dec_pm;
  logic        dec_fast;
  logic [1:0]  dec_tmode;

  logic [15:0] ir_q;

  mcuid_phase u_phase (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .phase_out (phase)
  );

  mcuid_fields u_fields (
    .word_in        (ir_q),
    .class_out      (dec_class),
    .incskip_out    (dec_incskip),
    .branch_out     (dec_branch),
    .ext_op_out     (dec_ext),
    .ext_idx_out    (dec_ext_idx),
    .file_out       (dec_file),
    .dest_out       (dec_dest),
    .access_out     (dec_access),
    .bit_num_out    (dec_bit),
    .literal_out    (dec_lit),
    .ptr_sel_out    (dec_psel),
    .pm_field_out   (dec_pm),
    .fast_out       (dec_fast),
    .table_mode_out (dec_tmode)
  );

  // ****************************************************************
  // state
  // ****************************************************************
  mcuid_pkg::mcuid_slot_t  slot_q;
  mcuid_pkg::mcuid_slot_t  slot_d;
  mcuid_pkg::mcuid_phase_t phase_q;
  mcuid_pkg::mcuid_class_t class_q;
  mcuid_pkg::mcuid_mode_t  mode_q;
  mcuid_pkg::mcuid_mode_t  mode_d;
  logic        kill_q;
  logic        kill_d;
  logic [15:0] pc_q;
  logic [15:0] pc_d;
  logic [7:0]  work_q;
  logic [7:0]  rd_q;
  logic [7:0]  sum_q;
  logic        zero_q;
  logic        file_rd_q;
  logic        file_wr_q;
  logic [7:0]  file_addr_q;
  logic [7:0]  bank_q;
  logic [15:0] op_word_q;
  logic [15:0] operand_q;
  logic        double_q;
  logic        nop_q;
  logic        dest_q;
  logic        access_q;
  logic [2:0]  bit_q;
  logic [7:0]  lit_q;
  logic [1:0]  psel_q;
  logic [10:0] pm_q;
  logic        fast_q;
  logic [1:0]  tmode_q;
  logic        ext_q;
  logic [2:0]  ext_idx_q;

  // ****************************************************************
  // decode of the current cycle
  // ****************************************************************
  logic        in_q1;
  logic        in_q2;
  logic        in_q3;
  logic        in_q4;
  logic        exec;
  logic        is_double;
  logic        next_double;
  logic        file_op;
  logic        do_incskip;
  logic        skip_now;
  logic        jump_now;
  logic        indexed;
  logic [7:0]  sum_d;
  logic [15:0] branch_off;

  assign in_q1       = phase == mcuid_pkg::MCUID_Q1;
  assign in_q2       = phase == mcuid_pkg::MCUID_Q2;
  assign in_q3       = phase == mcuid_pkg::MCUID_Q3;
  assign in_q4       = phase == mcuid_pkg::MCUID_Q4;
  assign exec        = slot_q == mcuid_pkg::MCUID_SL_EXEC;
  assign is_double   = mcuid_pkg::mcuid_is_double(ir_q); // see RULE2
  assign next_double = mcuid_pkg::mcuid_is_double(prog_data_in);
  assign file_op     = (dec_class == mcuid_pkg::MCUID_CL_BYTE) ||
                       (dec_class == mcuid_pkg::MCUID_CL_BIT);
  assign do_incskip  = exec && dec_incskip;
  // zero_q is fresh here: it was formed in the third quarter
  assign skip_now    = do_incskip && zero_q; // see RULE16
  assign jump_now    = exec && dec_branch; // see RULE12
  assign sum_d       = rd_q + `MCUID_BYTE_ONE; // see RULE15
  assign branch_off  = {{5{dec_pm[`MCUID_N_HI]}}, dec_pm};
  // see RULE18
  assign indexed     = !dec_access && ext_set_en_in &&
                       (dec_file <= `MCUID_IDX_MAX);

  // see RULE17
  always_comb begin
    if (dec_access) begin
      mode_d = mcuid_pkg::MCUID_MD_BANKED;
    end else if (indexed) begin
      mode_d = mcuid_pkg::MCUID_MD_INDEXED;
    end else begin
      mode_d = mcuid_pkg::MCUID_MD_ACCESS;
    end
  end

  // what the next cycle does with the word fetched now
  always_comb begin
    kill_d = 1'b0;
    case (slot_q)
      mcuid_pkg::MCUID_SL_EXEC: begin
        if (is_double) begin
          slot_d = mcuid_pkg::MCUID_SL_OPERAND; // see RULE13
        end else if (skip_now) begin
          slot_d = mcuid_pkg::MCUID_SL_FLUSH;
          kill_d = next_double; // see RULE16
        end else if (jump_now) begin
          slot_d = mcuid_pkg::MCUID_SL_FLUSH; // see RULE12
        end else begin
          slot_d = mcuid_pkg::MCUID_SL_EXEC;
        end
      end
      mcuid_pkg::MCUID_SL_OPERAND: begin
        slot_d = mcuid_pkg::MCUID_SL_EXEC;
      end
      mcuid_pkg::MCUID_SL_FLUSH: begin
        slot_d = kill_q ? mcuid_pkg::MCUID_SL_FLUSH :
                          mcuid_pkg::MCUID_SL_EXEC;
      end
      default: begin
        slot_d = mcuid_pkg::MCUID_SL_FLUSH;
      end
    endcase
  end

  assign pc_d = jump_now ? pc_q + branch_off : pc_q + `MCUID_PC_STEP;

  // ****************************************************************
  // fetch and cycle sequencing, once per fourth quarter
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      slot_q    <= mcuid_pkg::MCUID_SL_FLUSH;
      kill_q    <= 1'b0;
      pc_q      <= `MCUID_PC_RST;
      ir_q      <= `MCUID_WORD_ZERO;
      operand_q <= `MCUID_WORD_ZERO;
    end else if (in_q4) begin
      slot_q <= slot_d;
      kill_q <= kill_d;
      pc_q   <= pc_d;
      ir_q   <= prog_data_in;
      if (exec && is_double) begin
        operand_q <= prog_data_in; // see RULE10
      end
    end
  end

  // ****************************************************************
  // first quarter: decoded fields
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      class_q     <= mcuid_pkg::MCUID_CL_NOP;
      mode_q      <= mcuid_pkg::MCUID_MD_ACCESS;
      nop_q       <= 1'b1;
      double_q    <= 1'b0;
      op_word_q   <= `MCUID_WORD_ZERO;
      file_addr_q <= `MCUID_BYTE_ZERO;
      bank_q      <= `MCUID_BYTE_ZERO;
      dest_q      <= 1'b0;
      access_q    <= 1'b0;
      bit_q       <= 3'h0;
      lit_q       <= `MCUID_BYTE_ZERO;
      psel_q      <= 2'h0;
      pm_q        <= 11'h000;
      fast_q      <= 1'b0;
      tmode_q     <= 2'h0;
      ext_q       <= 1'b0;
      ext_idx_q   <= 3'h0;
    end else if (in_q1) begin
      // see RULE19
      class_q     <= exec ? dec_class : mcuid_pkg::MCUID_CL_NOP;
      nop_q       <= !exec;
      mode_q      <= mode_d;
      bank_q      <= dec_access ? bank_select_register_in :
                                  `MCUID_BYTE_ZERO;
      file_addr_q <= dec_file;
      op_word_q   <= ir_q;
      double_q    <= exec && is_double;
      dest_q      <= dec_dest;
      access_q    <= dec_access;
      bit_q       <= dec_bit;
      lit_q       <= dec_lit;
      psel_q      <= dec_psel;
      pm_q        <= dec_pm;
      fast_q      <= dec_fast;
      tmode_q     <= dec_tmode;
      // extended codes do nothing unless the extended set is on
      ext_q       <= exec && dec_ext && ext_set_en_in; // see RULE1
      ext_idx_q   <= dec_ext_idx;
    end
  end

  // ****************************************************************
  // quarters two to four: read, process, write
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      file_rd_q <= 1'b0;
      file_wr_q <= 1'b0;
      rd_q      <= `MCUID_BYTE_ZERO;
      sum_q     <= `MCUID_BYTE_ZERO;
      zero_q    <= 1'b0;
      work_q    <= `MCUID_BYTE_ZERO;
      phase_q   <= mcuid_pkg::MCUID_Q1;
    end else begin
      phase_q <= phase;
      if (in_q1) begin
        file_rd_q <= exec && file_op; // see RULE19
      end else if (in_q2) begin
        file_rd_q <= 1'b0;
        rd_q      <= file_rd_data_in;
      end
      if (in_q3) begin
        sum_q     <= sum_d;
        zero_q    <= sum_d == `MCUID_BYTE_ZERO;
        file_wr_q <= do_incskip && dec_dest; // see RULE6
      end else if (in_q4) begin
        file_wr_q <= 1'b0;
      end
      // status flags are never touched by the increment
      if (in_q4 && do_incskip && !dec_dest) begin
        work_q <= sum_q; // see RULE6, RULE15
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prog_addr_out        = pc_q;
  assign file_addr_out        = file_addr_q;
  assign bank_out             = bank_q;
  assign file_mode_out        = mode_q;
  assign file_rd_out          = file_rd_q;
  assign file_wr_out          = file_wr_q;
  assign file_wr_data_out     = sum_q;
  assign working_register_out = work_q;
  assign phase_out            = phase_q;
  assign class_out            = class_q;
  assign op_word_out          = op_word_q;
  assign operand_word_out     = operand_q;
  assign double_out           = double_q;
  assign nop_cycle_out        = nop_q;
  assign dest_out             = dest_q;
  assign access_out           = access_q;
  assign bit_num_out          = bit_q;
  assign literal_out          = lit_q;
  assign ptr_sel_out          = psel_q;
  assign pm_field_out         = pm_q;
  assign fast_out             = fast_q;
  assign table_mode_out       = tmode_q;
  assign ext_op_out           = ext_q;
  assign ext_idx_out          = ext_idx_q;

endmodule : mcuid_core

/* tb/mcuid_mem.sv */
// program memory and data file seen by the decoder core.
// assumes the bench loads rom and ram before each reset release.
`timescale 1ns/1ps

module mcuid_mem (
  // program side
  input  wire logic        clk_in,
  input  wire logic [15:0] prog_addr_in,
  output logic      [15:0] prog_data_out,
  // data side
  input  wire logic [7:0]  file_addr_in,
  input  wire logic        file_rd_in,
  input  wire logic        file_wr_in,
  input  wire logic [7:0]  file_wr_data_in,
  output logic      [7:0]  file_rd_data_out
);
  logic [15:0] rom [64];
  logic [7:0]  ram [256];

  assign prog_data_out = rom[prog_addr_in[5:0]];
  // idle bus shows the inverse, so a late sample never matches
  assign file_rd_data_out = file_rd_in ? ram[file_addr_in]
                                       : ~ram[file_addr_in];

  always @(posedge clk_in) begin
    if (file_wr_in) begin
      ram[file_addr_in] <= file_wr_data_in;
    end
  end
endmodule : mcuid_mem

/* tb/mcuid_core_assertions.sv */
// concurrent checks on the decoder core ports.
// assumes it is bound to mcuid_core with every pin by name.
`timescale 1ns/1ps

module mcuid_chk (
  input wire logic                    clk_in,
  input wire logic                    rstn_in,
  input wire logic                    file_rd_out,
  input wire logic                    file_wr_out,
  input wire logic [7:0]              file_rd_data_in,
  input wire logic [7:0]              file_wr_data_out,
  input wire logic [15:0]             prog_addr_out,
  input wire logic [7:0]              file_addr_out,
  input wire logic [7:0]              bank_out,
  input wire logic [7:0]              bank_select_register_in,
  input wire mcuid_pkg::mcuid_mode_t  file_mode_out,
  input wire mcuid_pkg::mcuid_class_t class_out,
  input wire logic                    access_out,
  input wire logic                    dest_out,
  input wire logic                    nop_cycle_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  rd_pulse_a: assert property (
    file_rd_out |=> !file_rd_out) else $error("read strobe too long");
  wr_space_a: assert property (
    file_wr_out |=> !file_wr_out [*3]) else $error("write spacing");
  wr_order_a: assert property (
    $rose(file_wr_out) |-> $past(file_rd_out, 2)) else $error("no read");
  wr_sum_a: assert property (
    file_wr_out |-> file_wr_data_out == $past(file_rd_data_in, 2) + 8'h01)
    else $error("write data is not read data plus one");
  wr_dest_a: assert property (
    file_wr_out |-> dest_out && class_out == mcuid_pkg::MCUID_CL_BYTE)
    else $error("file write with working destination");
  pc_hold_a: assert property (
    $changed(prog_addr_out) |=> $stable(prog_addr_out) [*3])
    else $error("program address held under four clocks");
  idx_mode_a: assert property (
    file_mode_out == mcuid_pkg::MCUID_MD_INDEXED |->
      !access_out && file_addr_out <= 8'h5F) else $error("indexed mode");
  bank_sel_a: assert property (
    file_rd_out && access_out |->
      file_mode_out == mcuid_pkg::MCUID_MD_BANKED &&
      bank_out == bank_select_register_in) else $error("banked access");
  nop_quiet_a: assert property (
    nop_cycle_out |-> !file_rd_out && !file_wr_out)
    else $error("strobe in a no-op cycle");
endmodule : mcuid_chk

/* tb/mcu_core_instruction_decode_tb.sv */
// self-checking bench of the decoder core with its memory model.
// assumes design, model and checker files are compiled before it.
`timescale 1ns/1ps

module mcu_core_instruction_decode_tb;
  typedef struct packed {
    logic [15:0]            word;
    logic [7:0]             init;
    logic [7:0]             cnt;
    logic                   ext;
    mcuid_pkg::mcuid_mode_t mode;
  } mcuid_row_t;

  // second word of each row bumps a counter at 80h unless skipped
  mcuid_row_t rows [7] = '{
    '{16'h3E10, 8'h05, 8'h11, 1'b0, mcuid_pkg::MCUID_MD_ACCESS},
    '{16'h3E11, 8'hFF, 8'h10, 1'b0, mcuid_pkg::MCUID_MD_ACCESS},
    '{16'h3C12, 8'h7F, 8'h11, 1'b1, mcuid_pkg::MCUID_MD_INDEXED},
    '{16'h3C13, 8'hFF, 8'h10, 1'b1, mcuid_pkg::MCUID_MD_INDEXED},
    '{16'h3F14, 8'h00, 8'h11, 1'b1, mcuid_pkg::MCUID_MD_BANKED},
    '{16'h3E60, 8'h01, 8'h11, 1'b1, mcuid_pkg::MCUID_MD_ACCESS},
    '{16'h3E5F, 8'h02, 8'h11, 1'b1, mcuid_pkg::MCUID_MD_INDEXED}};
  logic [15:0] prog [9] = '{16'h3E11, 16'hC000, 16'hF000, 16'h3E80,
                            16'hC000, 16'hF000, 16'h3E80, 16'hFEAB, 16'hD7FA};
  logic                    clk_in, rstn_in, ext, rd, wr, dst, acc, nopc;
  logic [7:0]              bank, fa, bo, rdat, wdat, work, f, sum;
  logic [15:0]             pa, pd;
  mcuid_pkg::mcuid_mode_t  md;
  mcuid_pkg::mcuid_class_t cls;
  int                      n_errors = 0;
  int                      n_tests = 0;
  int                      n;

  mcuid_core u_dut (.clk_in(clk_in), .rstn_in(rstn_in),
    .ext_set_en_in(ext), .bank_select_register_in(bank),
    .prog_addr_out(pa), .prog_data_in(pd), .file_addr_out(fa),
    .bank_out(bo), .file_mode_out(md), .file_rd_out(rd),
    .file_rd_data_in(rdat), .file_wr_out(wr), .file_wr_data_out(wdat),
    .working_register_out(work), .phase_out(), .class_out(cls),
    .op_word_out(), .operand_word_out(), .double_out(),
    .nop_cycle_out(nopc), .dest_out(dst), .access_out(acc),
    .bit_num_out(), .literal_out(), .ptr_sel_out(), .pm_field_out(),
    .fast_out(), .table_mode_out(), .ext_op_out(), .ext_idx_out());
  mcuid_mem u_mem (.clk_in(clk_in), .prog_addr_in(pa), .prog_data_out(pd),
    .file_addr_in(fa), .file_rd_in(rd), .file_wr_in(wr),
    .file_wr_data_in(wdat), .file_rd_data_out(rdat));

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8

  task automatic load();
    foreach (u_mem.rom[j]) u_mem.rom[j] = 16'hF000;
    u_mem.ram[8'h80] = 8'h10;
  endtask : load

  task automatic restart(input logic e);
    @(negedge clk_in);
    rstn_in = 1'b0;
    ext = e;
    repeat (10) @(negedge clk_in);
    rstn_in = 1'b1;
  endtask : restart

  // n ends as the clock count up to the strobe
  task automatic wait_sig(input logic use_wr);
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while ((use_wr ? wr : rd) !== 1'b1 && n < 99);
    if (n >= 99) begin
      n_errors++;
      $display("CHECK FAILED t=%0t strobe missing", $time);
    end
  endtask : wait_sig

  task automatic print_verdict();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end

  initial begin
    rstn_in = 1'b0;
    ext = 1'b0;
    bank = 8'h5A;
    foreach (rows[i]) begin
      load();
      u_mem.rom[0] = rows[i].word;
      u_mem.rom[1] = 16'h3E80;
      f = rows[i].word[7:0];
      sum = rows[i].init + 8'h01;
      u_mem.ram[f] = rows[i].init;
      restart(rows[i].ext);
      wait_sig(1'b0);
      chk8(fa, f);
      chk8({5'h00, md}, {5'h00, rows[i].mode});
      chk8({3'h0, cls}, {3'h0, mcuid_pkg::MCUID_CL_BYTE});
      if (rows[i].word[8]) chk8(bo, bank);
      repeat (24) @(negedge clk_in);
      chk8(u_mem.ram[f], rows[i].word[9] ? sum : rows[i].init);
      if (!rows[i].word[9]) chk8(work, sum);
      chk8(u_mem.ram[8'h80], rows[i].cnt);
    end
    // skip over a double word, run one, a lone second word, a branch back
    load();
    foreach (prog[k]) u_mem.rom[k] = prog[k];
    u_mem.ram[8'h11] = 8'hFF;
    u_mem.ram[8'hAB] = 8'hFF;
    restart(1'b0);
    wait_sig(1'b1);
    wait_sig(1'b1);
    chk8(8'(n), 8'h0C);
    wait_sig(1'b1);
    chk8(8'(n), 8'h0C);
    wait_sig(1'b1);
    chk8(8'(n), 8'h10);
    chk8(u_mem.ram[8'hAB], 8'hFF);
    chk8(u_mem.ram[8'h80], 8'h12);
    print_verdict();
  end
endmodule : mcu_core_instruction_decode_tb

bind mcuid_core mcuid_chk u_chk (.clk_in(clk_in), .rstn_in(rstn_in),
  .file_rd_out(file_rd_out), .file_wr_out(file_wr_out),
  .file_rd_data_in(file_rd_data_in), .file_wr_data_out(file_wr_data_out),
  .prog_addr_out(prog_addr_out), .file_addr_out(file_addr_out),
  .bank_out(bank_out), .bank_select_register_in(bank_select_register_in),
  .file_mode_out(file_mode_out), .class_out(class_out),
  .access_out(access_out), .dest_out(dest_out),
  .nop_cycle_out(nop_cycle_out));
